/* ufr_defs.vh */
// Purpose: Offsets, field positions, reset values and timing for ufr block.
// Assumes: 32-bit APB, word-aligned registers.
// Notes: Definitions only.
`ifndef UFR_DEFS_VH
`define UFR_DEFS_VH
`define UFR_OFF_FLAG_CLEAR 12'h020
`define UFR_OFF_RX_CHAR 12'h024
`define UFR_OFF_TX_CHAR 12'h028
`define UFR_OFF_COHERENCE 12'h0C0
`define UFR_OFF_RX_FIFO_CS 12'h0D0
`define UFR_OFF_STATUS 12'h01C
`define UFR_OFF_CONFIG 12'h030
`define UFR_CLR_MASK 32'h0013_1B5F
`define UFR_RFCS_RESET 32'h0000_0400
`define UFR_BIT_EARLY_PARITY_FLAG 8
`define UFR_BIT_HCM 0
`define UFR_BIT_RX_FIFO_FULL_IRQ_FLAG 15
`define UFR_BIT_RFF 11
`define UFR_BIT_RFE 10
`define UFR_BIT_RX_FIFO_FULL_IRQ_ENABLE 9
`define UFR_BIT_RX_FIFO_ENABLE 8
`define UFR_BIT_EARLY_SMARTCARD_NACK 0
`define UFR_CFG_PARITY_ENABLE 0
`define UFR_CFG_WL9 1
`define UFR_CFG_DEEP_SLEEP_WAKE_ENABLE 2
`define UFR_CFG_SCEN 3
`define UFR_FIFO_DEPTH 4
`define UFR_CNT_W 3
`define UFR_OVS 16
`define UFR_NACK_EARLY 1
`endif

/* ufr_peer.sv */
// Purpose: Frame engine stand-in driving receive and flag strobes.
// Assumes: Strobes last one pclk cycle.
// Notes: Released data shows the inverse so stale values never match.
`timescale 1ns/1ps
`default_nettype none
module ufr_peer
(
  // Clock
  input wire logic pclk,
  // Engine strobes
  output logic [11:0] flag_set,
  output logic rx_char_valid,
  output logic [8:0] rx_char,
  output logic rx_parity_bad,
  output logic rx_last_bit,
  output logic rx_sample_tick,
  output logic rx_pin,
  output logic tx_taken,
  input wire logic tx_char_valid_r
);
  initial
  begin
    {flag_set, rx_char_valid, rx_char, rx_parity_bad} = '0;
    {rx_last_bit, rx_sample_tick, tx_taken} = '0;
    rx_pin = 1'b1;
  end
  always @(posedge pclk)
  begin
    rx_sample_tick <= !rx_sample_tick;
    tx_taken <= tx_char_valid_r && !tx_taken;
  end
  task automatic flags(input logic [11:0] f);
    @(posedge pclk);
    flag_set <= f;
    @(posedge pclk);
    flag_set <= 12'h000;
  endtask
  // Parity is judged at the last bit, before the character lands.
  task automatic frame(input logic [8:0] c, input logic bad);
    @(posedge pclk);
    rx_last_bit <= 1'b1;
    rx_parity_bad <= bad;
    @(posedge pclk);
    rx_last_bit <= 1'b0;
    rx_parity_bad <= 1'b0;
    repeat (3) @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
  endtask
endmodule // ufr_peer
`default_nettype wire

/* ufr_regs.v */
// Purpose: Serial port flag clear, data, coherence and receive FIFO regs.
// Assumes: One pclk domain; frame engines deliver same-clock strobes.
// Notes: The serial data input passes a two-stage synchroniser.
//
// Contract
// - Writing one to bit 20 clears the deep-sleep wakeup flag.
// - Writing one to bit 17 clears the address match flag.
// - Writing one to bit 12 clears the end-of-block flag.
// - Writing one to bit 11 clears the receiver timeout flag.
// - Writing one to bit 9 clears the clear-to-send change flag.
// - Writing one to bit 8 clears the LIN break flag.
// - Writing one to bit 6 clears the transmit complete flag.
// - Writing one to bit 4 clears the idle line flag.
// - Writing one to bit 3 clears the overrun flag.
// - Writing one to bit 2 clears the noise error flag.
// - Writing one to bit 1 clears the framing error flag.
// - Writing one to bit 0 clears the parity error flag.
// - Receive data shows character in bits 8:0, parity in top bit.
// - Transmit data bits 8:0; top data bit replaced by parity.
// - Early parity flag bit 8 sets on bad parity; write zero clears.
// - Mode bit 0 picks request-to-send from not-empty or frame end.
// - FIFO enable bit 8 settable only while deep-sleep wake enabled.
// - FIFO count bits 14:12, full bit 11, empty bit 10; reset 0x400.
// - Full sets flag bit 15; enable bit 9 raises irq; zero clears.
// - Smartcard early NACK fires one sixteenth bit earlier.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ufr_defs.vh"
module ufr_regs
(
  // APB clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Flag set events from frame engines
  input wire [11:0] flag_set,
  // Receive frame engine
  input wire rx_char_valid,
  input wire [8:0] rx_char,
  input wire rx_parity_bad,
  input wire rx_last_bit,
  input wire rx_sample_tick,
  input wire rx_pin,
  // Transmit engine
  input wire tx_taken,
  output reg [8:0] tx_char_r,
  output reg tx_char_valid_r,
  // Flow control and smartcard
  output reg request_to_send_n,
  output reg nack_pulse_r,
  output reg rx_fifo_irq_r,
  output reg [11:0] status_flags_r
);
  reg [31:0] clr_mask;
  reg rx_meta_r;
  reg rx_sync_r;
  reg early_parity_flag_r;
  reg flow_coherence_mode_r;
  reg frame_end_r;
  reg rx_fifo_full_irq_flag_r;
  reg rx_fifo_full_irq_enable_r;
  reg rx_fifo_enable_r;
  reg early_smartcard_nack_r;
  reg [3:0] cfg_r;
  reg [8:0] rx_hold_r;
  reg rx_hold_valid_r;
  reg [3:0] nack_cnt_r;
  reg nack_arm_r;
  reg [31:0] rd_nxt;
  // Kept 32 bits wide so the 4-bit counter compare takes a deliberate slice.
  localparam [31:0] NACK_LATE = `UFR_OVS - 1;
  localparam [31:0] NACK_SOON = `UFR_OVS - 1 - `UFR_NACK_EARLY;
  wire wr;
  wire rd;
  wire [8:0] fifo_rdata;
  wire [`UFR_CNT_W-1:0] fifo_count;
  wire fifo_full;
  wire fifo_empty;
  wire rx_ready;
  wire [8:0] rx_view;
  wire rx_pop;
  wire [8:0] tx_fix;
  wire parity_bit;
  wire [3:0] nack_delay;
  wire [11:0] flag_clear;
  wire [31:0] clr_word;
  wire [31:0] rfcs_word;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign rx_pop = rd && paddr == `UFR_OFF_RX_CHAR;
  assign fifo_full = fifo_count == 3'h4;
  assign fifo_empty = fifo_count == 3'h0;
  assign rx_ready = rx_fifo_enable_r ? !fifo_empty : rx_hold_valid_r;
  assign rx_view = rx_fifo_enable_r ? fifo_rdata : rx_hold_r;

  // Gather the write-one-to-clear positions into one flag vector.
  function [11:0] clr_pick;
    input [31:0] w;
    begin
      clr_pick = {w[20], w[17], w[12], w[11], w[9], w[8],
                  w[6], w[4], w[3], w[2], w[1], w[0]};
    end
  endfunction
  assign clr_word = (wr && paddr == `UFR_OFF_FLAG_CLEAR) ? pwdata
                    : 32'h0000_0000;
  assign flag_clear = clr_pick(clr_word & `UFR_CLR_MASK);

  // Parity substitution covers the top data bit for either length.
  assign parity_bit = cfg_r[`UFR_CFG_WL9] ? ^pwdata[7:0] : ^pwdata[6:0];
  assign tx_fix = !cfg_r[`UFR_CFG_PARITY_ENABLE] ? pwdata[8:0]
                  : cfg_r[`UFR_CFG_WL9] ? {parity_bit, pwdata[7:0]}
                  : {1'b0, parity_bit, pwdata[6:0]};
  assign nack_delay = early_smartcard_nack_r ? NACK_SOON[3:0]
                      : NACK_LATE[3:0];
  assign rfcs_word = {16'h0000, rx_fifo_full_irq_flag_r, fifo_count,
                      fifo_full, fifo_empty, rx_fifo_full_irq_enable_r,
                      rx_fifo_enable_r, 7'h00, early_smartcard_nack_r};

  ufr_rx_fifo u_fifo
  (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .flush(!rx_fifo_enable_r),
    .push(rx_char_valid && rx_fifo_enable_r),
    .wdata(rx_char),
    .pop(rx_pop && rx_fifo_enable_r),
    .rdata(fifo_rdata),
    .count_r(fifo_count)
  );

  // Reserved bits of every register come back as zero.
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    if (paddr == `UFR_OFF_RX_CHAR)
      rd_nxt = {23'h000000, rx_view};
    else if (paddr == `UFR_OFF_TX_CHAR)
      rd_nxt = {23'h000000, tx_char_r};
    else if (paddr == `UFR_OFF_COHERENCE)
      rd_nxt = {23'h000000, early_parity_flag_r, 7'h00,
                flow_coherence_mode_r};
    else if (paddr == `UFR_OFF_RX_FIFO_CS)
      rd_nxt = rfcs_word;
    else if (paddr == `UFR_OFF_STATUS)
      rd_nxt = {19'h00000, rx_ready, status_flags_r};
    else if (paddr == `UFR_OFF_CONFIG)
      rd_nxt = {28'h0000000, cfg_r};
  end

  // The pin is only synchronised, and nothing reads rx_sync_r; two stages guard metastability.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta_r <= 1'b0;
      rx_sync_r <= 1'b0;
    end
    else if (ce)
    begin
      rx_meta_r <= rx_pin;
      rx_sync_r <= rx_meta_r;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      status_flags_r <= 12'h000;
      early_parity_flag_r <= 1'b0;
      flow_coherence_mode_r <= 1'b0;
      frame_end_r <= 1'b0;
      rx_fifo_full_irq_flag_r <= 1'b0;
      rx_fifo_full_irq_enable_r <= 1'b0;
      rx_fifo_enable_r <= 1'b0;
      early_smartcard_nack_r <= 1'b0;
      cfg_r <= 4'h0;
      rx_hold_r <= 9'h000;
      rx_hold_valid_r <= 1'b0;
      tx_char_r <= 9'h000;
      tx_char_valid_r <= 1'b0;
      request_to_send_n <= 1'b1;
      nack_pulse_r <= 1'b0;
      nack_cnt_r <= 4'h0;
      nack_arm_r <= 1'b0;
      rx_fifo_irq_r <= 1'b0;
    end
    else if (ce)
    begin
      // Zero-wait slave: pready rises at the setup cycle's following edge.
      pready <= psel && !penable;
      pslverr <= 1'b0;
      // Loaded at the setup edge so read data stands together with pready.
      if (psel && !penable && !pwrite)
        prdata <= rd_nxt;
      // Set wins over clear so no event is lost in the clear cycle.
      status_flags_r <= (status_flags_r & ~flag_clear) | flag_set;
      if (wr && paddr == `UFR_OFF_TX_CHAR)
      begin
        tx_char_r <= tx_fix;
        tx_char_valid_r <= 1'b1;
      end
      else if (tx_taken)
        tx_char_valid_r <= 1'b0;
      if (rx_char_valid && !rx_fifo_enable_r)
      begin
        rx_hold_r <= rx_char;
        rx_hold_valid_r <= 1'b1;
      end
      else if (rx_pop)
        rx_hold_valid_r <= 1'b0;
      if (wr && paddr == `UFR_OFF_CONFIG)
        cfg_r <= pwdata[3:0];
      if (wr && paddr == `UFR_OFF_COHERENCE)
      begin
        flow_coherence_mode_r <= pwdata[`UFR_BIT_HCM];
        if (!pwdata[`UFR_BIT_EARLY_PARITY_FLAG])
          early_parity_flag_r <= rx_parity_bad;
      end
      else if (rx_parity_bad)
        early_parity_flag_r <= 1'b1;
      if (wr && paddr == `UFR_OFF_RX_FIFO_CS)
      begin
        rx_fifo_full_irq_enable_r <= pwdata[`UFR_BIT_RX_FIFO_FULL_IRQ_ENABLE];
        rx_fifo_enable_r <= pwdata[`UFR_BIT_RX_FIFO_ENABLE] &&
                            (cfg_r[`UFR_CFG_DEEP_SLEEP_WAKE_ENABLE] || rx_fifo_enable_r);
        early_smartcard_nack_r <= pwdata[`UFR_BIT_EARLY_SMARTCARD_NACK];
        if (!pwdata[`UFR_BIT_RX_FIFO_FULL_IRQ_FLAG])
          rx_fifo_full_irq_flag_r <= fifo_full;
      end
      else if (fifo_full)
        rx_fifo_full_irq_flag_r <= 1'b1;
      rx_fifo_irq_r <= rx_fifo_full_irq_flag_r &&
                       rx_fifo_full_irq_enable_r;
      // Frame end holds while a character is ready or landing, then clears.
      if (rx_last_bit)
        frame_end_r <= 1'b1;
      else if (!rx_ready && !rx_char_valid)
        frame_end_r <= 1'b0;
      request_to_send_n <= flow_coherence_mode_r
                           ? (frame_end_r || rx_last_bit)
                           : rx_ready;
      // NACK counts oversample ticks from the parity sample point.
      nack_pulse_r <= 1'b0;
      if (rx_parity_bad && cfg_r[`UFR_CFG_SCEN])
      begin
        nack_arm_r <= 1'b1;
        nack_cnt_r <= 4'h0;
      end
      else if (nack_arm_r && rx_sample_tick)
      begin
        if (nack_cnt_r == nack_delay)
        begin
          nack_arm_r <= 1'b0;
          nack_pulse_r <= 1'b1;
        end
        else
          nack_cnt_r <= nack_cnt_r + 4'h1;
      end
    end
  end
endmodule // ufr_regs
`default_nettype wire

/* ufr_regs_asserts.sv */
// Purpose: Port checks for the register slice.
// Assumes: One pclk domain, APB on the ports.
// Notes: Set beats clear, so clears are checked with no set.
`timescale 1ns/1ps
`default_nettype none
module ufr_regs_chk
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flags
  input wire logic [11:0] flag_set,
  input wire logic [11:0] status_flags_r
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence clr_s;
    psel && penable && pready && pwrite && paddr == 12'h020;
  endsequence
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("pready too long");
  ready_setup_a:
    assert property (setup_s |=> pready) else $error("no pready");
  no_slverr_a:
    assert property (!pslverr) else $error("pslverr raised");
  unmapped_read_a:
    assert property (setup_s ##0 !pwrite && paddr == 12'h100 |=>
      prdata == 32'h0) else $error("unmapped read not zero");
  parity_clr_a:
    assert property (clr_s ##0 pwdata[0] && !flag_set[0] |=>
      !status_flags_r[0]) else $error("parity flag kept");
  wake_clr_a:
    assert property (clr_s ##0 pwdata[20] && !flag_set[11] |=>
      !status_flags_r[11]) else $error("wakeup flag kept");
  zero_clr_a:
    assert property (clr_s ##0 pwdata == 32'h0 |=> status_flags_r ==
      ($past(status_flags_r) | $past(flag_set))) else $error("flag lost");
  overrun_set_a:
    assert property (flag_set[3] |=> status_flags_r[3])
      else $error("overrun not set");
endmodule // ufr_regs_chk
bind ufr_regs ufr_regs_chk chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flag_set(flag_set), .status_flags_r(status_flags_r));
`default_nettype wire

/* ufr_rx_fifo.v */
// Purpose: Receive character FIFO with count; full and empty are decoded from count_r in ufr_regs.
// Assumes: Push and pop come from logic on pclk.
// Notes: A push while full is dropped unless a pop comes in the same cycle; nothing here flags overrun.
`timescale 1ns/1ps
`default_nettype none
`include "ufr_defs.vh"
module ufr_rx_fifo
(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire flush,
  // Write side
  input wire push,
  input wire [8:0] wdata,
  // Read side
  input wire pop,
  output wire [8:0] rdata,
  output reg [`UFR_CNT_W-1:0] count_r
);
  reg [8:0] mem [0:`UFR_FIFO_DEPTH-1];
  reg [1:0] wptr_r;
  reg [1:0] rptr_r;
  wire do_push;
  wire do_pop;
  assign do_pop = pop && (count_r != 3'h0);
  assign do_push = push && (count_r != 3'h4 || do_pop);
  assign rdata = mem[rptr_r];
  always @(posedge pclk)
  begin
    if (ce && do_push)
      mem[wptr_r] <= wdata;
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_r <= 2'h0;
      rptr_r <= 2'h0;
      count_r <= 3'h0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wptr_r <= 2'h0;
        rptr_r <= 2'h0;
        count_r <= 3'h0;
      end
      else
      begin
        if (do_push)
          wptr_r <= wptr_r + 2'h1;
        if (do_pop)
          rptr_r <= rptr_r + 2'h1;
        if (do_push && !do_pop)
          count_r <= count_r + 3'h1;
        else if (do_pop && !do_push)
          count_r <= count_r - 3'h1;
      end
    end
  end
endmodule // ufr_rx_fifo
`default_nettype wire

/* usart_flag_clear_data_fifo_regs_test.sv */
// Purpose: Register-level test of the serial port slice.
// Assumes: One wait-free APB access; read data stands after it.
// Notes: Waits are bounded.
`timescale 1ns/1ps
`default_nettype none
module usart_flag_clear_data_fifo_regs_test;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire [31:0] prdata;
  wire pready, pslverr, rx_char_valid, rx_parity_bad, rx_last_bit;
  wire rx_sample_tick, rx_pin, tx_taken, tx_char_valid_r, rts_n, nack;
  wire rx_fifo_irq_r;
  wire [11:0] flag_set, status_flags_r;
  wire [8:0] rx_char, tx_char_r;
  int n_errors = 0;
  int checked = 0;
  int i;
  int pos[12] = '{0, 1, 2, 3, 4, 6, 8, 9, 11, 12, 17, 20};
  always #20 pclk = !pclk;
  ufr_regs dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flag_set(flag_set), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_parity_bad(rx_parity_bad), .rx_last_bit(rx_last_bit),
    .rx_sample_tick(rx_sample_tick), .rx_pin(rx_pin), .tx_taken(tx_taken),
    .tx_char_r(tx_char_r), .tx_char_valid_r(tx_char_valid_r),
    .request_to_send_n(rts_n), .nack_pulse_r(nack),
    .rx_fifo_irq_r(rx_fifo_irq_r), .status_flags_r(status_flags_r));
  ufr_peer peer (.pclk(pclk), .flag_set(flag_set),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_parity_bad(rx_parity_bad), .rx_last_bit(rx_last_bit),
    .rx_sample_tick(rx_sample_tick), .rx_pin(rx_pin), .tx_taken(tx_taken),
    .tx_char_valid_r(tx_char_valid_r));
  task automatic give_verdict;
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  // Whole words only, as the slice does not decode byte lanes.
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      n_errors++;
      give_verdict();
    end
    q = prdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [11:0] a,
    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(what, e, q);
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd("fifo reset", 12'h0D0, 32'h0000_0400);
    rd("coherence reset", 12'h0C0, 32'h0);
    rd("unmapped", 12'h100, 32'h0);
    peer.flags(12'hFFF);
    wr(12'h020, 32'h0);
    rd("zero clear", 12'h01C, 32'hFFF);
    for (i = 0; i < 12; i++)
    begin
      wr(12'h020, 32'h1 << pos[i]);
      @(posedge pclk);
      cmp("flags", {20'h0, 12'hFFF << (i + 1)}, {20'h0, status_flags_r});
    end
    wr(12'h030, 32'h1);
    peer.frame(9'h0A5, 1'b1);
    rd("early parity", 12'h0C0, 32'h100);
    wr(12'h0C0, 32'h0);
    rd("early parity clear", 12'h0C0, 32'h0);
    rd("rx char", 12'h024, 32'h0A5);
    wr(12'h028, 32'h1FF);
    @(posedge pclk);
    cmp("tx char", 32'h0FF, {23'h0, tx_char_r});
    wr(12'h0D0, 32'h100);
    rd("fifo refused", 12'h0D0, 32'h400);
    wr(12'h030, 32'h4);
    wr(12'h0D0, 32'h300);
    for (i = 0; i < 4; i++)
      peer.frame(9'h0A0 + i, 1'b0);
    rd("fifo full", 12'h0D0, 32'hCB00);
    cmp("fifo irq", {31'h0, rx_fifo_irq_r}, 32'h1);
    rd("fifo data", 12'h024, 32'h0A0);
    wr(12'h0D0, 32'h300);
    rd("fifo irq clear", 12'h0D0, 32'h3300);
    for (i = 1; i < 4; i++)
      rd("fifo data", 12'h024, 32'h0A0 + i);
    rd("fifo empty", 12'h0D0, 32'h0700);
    give_verdict();
  end
endmodule // usart_flag_clear_data_fifo_regs_test
`default_nettype wire
